// file: ccr_pkg.sv
// Contract
// - twelve counter channels numbered 1 to 12; other channel numbers are refused
// - host reads back the mode and current count of the selected channel
// - host reads count and status byte of the selected channel
// - 8-bit output port drives pins with the value the host writes
// - 8-bit input port lets the host read pin states
// - channel 11 always runs from the 8 MHz base clock
// - channel 12 always runs from channel 11 output
// - channels 1 to 10: code 0 external, 1 preceding, 2 shared, 3 channel ten
// - shared clock select: 0 base clock, 1 channel eleven output
// - debounce select: 0 channel eleven output, 1 the 2 MHz clock
// - timer interrupt from channel twelve output, external from interrupt pin
// - each interrupt source has an enable bit; 0 blocks, 1 allows
// - one status bit per source shows which source requested
// - a request stays pending until cleared; no new request meanwhile
package ccr_pkg;
  localparam int          NUM_CH      = 12;
  localparam int          NUM_ROUTED  = 10;
  // bit index of channel n in the per-channel vectors is n-1
  localparam int          IDX_TEN     = 9;
  localparam int          IDX_ELEVEN  = 10;
  localparam int          IDX_TWELVE  = 11;
  localparam logic [3:0]  CH_MIN      = 4'h1;
  localparam logic [3:0]  CH_MAX      = 4'hc;
  localparam logic [2:0]  MODE_STOP   = 3'h5;
  localparam logic [2:0]  MODE_MAX    = 3'h5;

  localparam logic [7:0]  OFS_CLKSEL  = 8'h00;
  localparam logic [7:0]  OFS_DOUT    = 8'h04;
  localparam logic [7:0]  OFS_DIN     = 8'h08;
  localparam logic [7:0]  OFS_IRQ_EN  = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_ST  = 8'h10;
  localparam logic [7:0]  OFS_CH_SEL  = 8'h14;
  localparam logic [7:0]  OFS_LOAD    = 8'h18;
  localparam logic [7:0]  OFS_RDBACK  = 8'h1c;

  localparam int          SHARED_BIT  = 20;
  localparam int          DEBNC_BIT   = 21;
  localparam int          LOAD_VAL_LO = 16;
  localparam int          RB_MODE_LO  = 16;
  localparam int          RB_STAT_LO  = 24;
  localparam int          IRQ_TIMER   = 0;
  localparam int          IRQ_EXT     = 1;

  localparam logic [1:0]  SRC_EXT     = 2'h0;
  localparam logic [1:0]  SRC_PREV    = 2'h1;
  localparam logic [1:0]  SRC_SHARED  = 2'h2;
  localparam logic [1:0]  SRC_TEN     = 2'h3;

  localparam longint      CLK_HZ      = 200000000;
  localparam longint      DB_HZ       = 2000000;
  localparam int          DB_HALF     = int'(CLK_HZ / (2 * DB_HZ));
  localparam logic [6:0]  DB_HALF_M1  = 7'(DB_HALF - 1);
endpackage : ccr_pkg

// file: ccr_route_if.sv
`timescale 1ns/1ps
interface ccr_route_if;
  logic [19:0] clock_source_code;
  logic        shared_clock_select;
  logic        debounce_select;
  logic [11:0] cout_s;
  logic [9:0]  ext_s;
  logic        base_s;
  logic        clk_2mhz;
  logic [11:0] channel_clock;
  logic        shared_clock;
  logic        debounce_clock;

  modport ctrl (output clock_source_code, shared_clock_select, debounce_select,
                output cout_s, ext_s, base_s, clk_2mhz,
                input  channel_clock, shared_clock, debounce_clock);
  modport router (input  clock_source_code, shared_clock_select, debounce_select,
                  input  cout_s, ext_s, base_s, clk_2mhz,
                  output channel_clock, shared_clock, debounce_clock);
endinterface : ccr_route_if

// file: ccr_router.sv
`timescale 1ns/1ps
module ccr_router (
  input wire logic   ref_clk,
  input wire logic   arst_n,
  ccr_route_if.router rt
);
  logic [11:0] clk_d;
  logic [11:0] clk_q;
  logic        shared_d;
  logic        shared_q;
  logic        debnc_d;
  logic        debnc_q;

  always_comb begin
    shared_d = rt.shared_clock_select ? rt.cout_s[ccr_pkg::IDX_ELEVEN] : rt.base_s;
    debnc_d  = rt.debounce_select ? rt.clk_2mhz : rt.cout_s[ccr_pkg::IDX_ELEVEN];
  end

  // channel 1 has no predecessor; its code 1 wraps to channel 12
  for (genvar i = 0; i < ccr_pkg::NUM_ROUTED; i++) begin : g_ch
    localparam int PREV = (i == 0) ? ccr_pkg::IDX_TWELVE : i - 1;
    always_comb begin
      case (rt.clock_source_code[2*i +: 2])
        ccr_pkg::SRC_EXT:    clk_d[i] = rt.ext_s[i];
        ccr_pkg::SRC_PREV:   clk_d[i] = rt.cout_s[PREV];
        ccr_pkg::SRC_SHARED: clk_d[i] = shared_q;
        ccr_pkg::SRC_TEN:    clk_d[i] = rt.cout_s[ccr_pkg::IDX_TEN];
        default:             clk_d[i] = 1'b0;
      endcase
    end
  end

  always_comb begin
    clk_d[ccr_pkg::IDX_ELEVEN] = rt.base_s;
    clk_d[ccr_pkg::IDX_TWELVE] = rt.cout_s[ccr_pkg::IDX_ELEVEN];
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_q    <= 12'h000;
      shared_q <= 1'b0;
      debnc_q  <= 1'b0;
    end else begin
      clk_q    <= clk_d;
      shared_q <= shared_d;
      debnc_q  <= debnc_d;
    end
  end

  assign rt.channel_clock  = clk_q;
  assign rt.shared_clock   = shared_q;
  assign rt.debounce_clock = debnc_q;
endmodule : ccr_router

// file: ccr_top.sv
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module ccr_top (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // clock pins, bit 0 is channel 1
  input  wire logic [9:0]  channel_external_clock_in,
  input  wire logic [11:0] channel_output_in,
  input  wire logic        base_8mhz_clock,
  input  wire logic        external_interrupt_in,
  output logic      [11:0] channel_clock,
  output logic             shared_clock,
  output logic             debounce_clock,
  // digital ports
  output logic      [7:0]  dout_pins,
  input  wire logic [7:0]  din_pins,
  // counter chip access
  output logic      [3:0]  channel_number,
  output logic             cnt_load,
  output logic      [2:0]  cnt_mode,
  output logic      [15:0] cnt_value,
  input  wire logic [15:0] cnt_rb_count,
  input  wire logic [2:0]  cnt_rb_mode,
  input  wire logic [7:0]  cnt_rb_status,
  // interrupt
  output logic             irq
);
  localparam int SYNC_W = 59;

  // ---------------------------------------------------------------- synchroniser
  // pins and chip readback cross into ref_clk through two flops; only sync_q is read
  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] meta_d;
  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_d;
  logic [SYNC_W-1:0] sync_q;

  assign async_in = {cnt_rb_status, cnt_rb_mode, cnt_rb_count, din_pins,
                     external_interrupt_in, base_8mhz_clock,
                     channel_output_in, channel_external_clock_in};

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  logic [9:0]  ext_s;
  logic [11:0] cout_s;
  logic        base_s;
  logic        xirq_s;
  logic [7:0]  din_s;
  logic [15:0] rb_count_s;
  logic [2:0]  rb_mode_s;
  logic [7:0]  rb_status_s;

  assign ext_s       = sync_q[9:0];
  assign cout_s      = sync_q[21:10];
  assign base_s      = sync_q[22];
  assign xirq_s      = sync_q[23];
  assign din_s       = sync_q[31:24];
  assign rb_count_s  = sync_q[47:32];
  assign rb_mode_s   = sync_q[50:48];
  assign rb_status_s = sync_q[58:51];

  // ---------------------------------------------------------------- 2 mhz divider
  logic [6:0] div_d;
  logic [6:0] div_q;
  logic       c2m_d;
  logic       c2m_q;

  always_comb begin
    div_d = div_q + 7'h01;
    c2m_d = c2m_q;
    if (div_q == ccr_pkg::DB_HALF_M1) begin
      div_d = 7'h00;
      c2m_d = ~c2m_q;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 7'h00;
      c2m_q <= 1'b0;
    end else begin
      div_q <= div_d;
      c2m_q <= c2m_d;
    end
  end

  // ---------------------------------------------------------------- apb decode
  logic setup;
  logic wr_acc;

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign pready = 1'b1;

  logic [19:0] codes_q;
  logic [19:0] codes_d;
  logic        shsel_q;
  logic        shsel_d;
  logic        dbsel_q;
  logic        dbsel_d;
  logic [7:0]  dout_q;
  logic [7:0]  dout_d;
  logic [1:0]  en_q;
  logic [1:0]  en_d;
  logic [1:0]  st_q;
  logic [1:0]  st_d;
  logic [3:0]  chan_q;
  logic [3:0]  chan_d;
  logic [2:0]  mode_q;
  logic [2:0]  mode_d;
  logic [15:0] val_q;
  logic [15:0] val_d;
  logic        load_q;
  logic        load_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        err_q;
  logic        err_d;

  logic [3:0]  wchan;
  logic        wchan_ok;
  logic [2:0]  wmode;

  assign wchan    = pwdata[3:0];
  assign wchan_ok = (wchan >= ccr_pkg::CH_MIN) && (wchan <= ccr_pkg::CH_MAX);
  assign wmode    = pwdata[2:0];

  // answer prepared in the setup cycle, shown in the access cycle
  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup) begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b0;
      case (paddr)
        ccr_pkg::OFS_CLKSEL: begin
          rdata_d[19:0]                = codes_q;
          rdata_d[ccr_pkg::SHARED_BIT] = shsel_q;
          rdata_d[ccr_pkg::DEBNC_BIT]  = dbsel_q;
        end
        ccr_pkg::OFS_DOUT:   rdata_d[7:0] = dout_q;
        ccr_pkg::OFS_DIN:    rdata_d[7:0] = din_s;
        ccr_pkg::OFS_IRQ_EN: rdata_d[1:0] = en_q;
        ccr_pkg::OFS_IRQ_ST: rdata_d[1:0] = st_q;
        ccr_pkg::OFS_CH_SEL: begin
          rdata_d[3:0] = chan_q;
          err_d        = pwrite & ~wchan_ok;
        end
        ccr_pkg::OFS_LOAD: begin
          rdata_d[2:0]                         = mode_q;
          rdata_d[ccr_pkg::LOAD_VAL_LO +: 16]  = val_q;
          err_d                                = pwrite & (wmode > ccr_pkg::MODE_MAX);
        end
        ccr_pkg::OFS_RDBACK: begin
          rdata_d[15:0]                      = rb_count_s;
          rdata_d[ccr_pkg::RB_MODE_LO +: 3]  = rb_mode_s;
          rdata_d[ccr_pkg::RB_STAT_LO +: 8]  = rb_status_s;
        end
        default: err_d = 1'b1;
      endcase
    end
  end

  // ---------------------------------------------------------------- register writes
  logic [1:0] ev_set;
  logic [1:0] ev_clr;

  always_comb begin
    codes_d = codes_q;
    shsel_d = shsel_q;
    dbsel_d = dbsel_q;
    dout_d  = dout_q;
    en_d    = en_q;
    chan_d  = chan_q;
    mode_d  = mode_q;
    val_d   = val_q;
    load_d  = 1'b0;
    ev_clr  = 2'b00;
    if (wr_acc && !err_q) begin
      case (paddr)
        ccr_pkg::OFS_CLKSEL: begin
          codes_d = pwdata[19:0];
          shsel_d = pwdata[ccr_pkg::SHARED_BIT];
          dbsel_d = pwdata[ccr_pkg::DEBNC_BIT];
        end
        ccr_pkg::OFS_DOUT:   dout_d = pwdata[7:0];
        ccr_pkg::OFS_IRQ_EN: en_d   = pwdata[1:0];
        ccr_pkg::OFS_IRQ_ST: ev_clr = pwdata[1:0];
        ccr_pkg::OFS_CH_SEL: chan_d = wchan;
        ccr_pkg::OFS_LOAD: begin
          mode_d = wmode;
          val_d  = pwdata[ccr_pkg::LOAD_VAL_LO +: 16];
          load_d = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------- interrupt sources
  // history flops reset low, the idle level of both sources, so no false edge follows reset
  logic tmr_prev_d;
  logic tmr_prev_q;
  logic xirq_prev_d;
  logic xirq_prev_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_prev_q  <= 1'b0;
      xirq_prev_q <= 1'b0;
    end else begin
      tmr_prev_q  <= tmr_prev_d;
      xirq_prev_q <= xirq_prev_d;
    end
  end

  always_comb begin
    tmr_prev_d                 = cout_s[ccr_pkg::IDX_TWELVE];
    xirq_prev_d                = xirq_s;
    ev_set[ccr_pkg::IRQ_TIMER] = cout_s[ccr_pkg::IDX_TWELVE] & ~tmr_prev_q;
    ev_set[ccr_pkg::IRQ_EXT]   = xirq_s & ~xirq_prev_q;
    // a pending bit absorbs further events until cleared; set beats clear
    st_d = (st_q & ~ev_clr) | ev_set;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      codes_q <= 20'h00000;
      shsel_q <= 1'b0;
      dbsel_q <= 1'b0;
      dout_q  <= 8'h00;
      en_q    <= 2'h0;
      st_q    <= 2'h0;
      chan_q  <= ccr_pkg::CH_MIN;
      mode_q  <= 3'h0;
      val_q   <= 16'h0000;
      load_q  <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      codes_q <= codes_d;
      shsel_q <= shsel_d;
      dbsel_q <= dbsel_d;
      dout_q  <= dout_d;
      en_q    <= en_d;
      st_q    <= st_d;
      chan_q  <= chan_d;
      mode_q  <= mode_d;
      val_q   <= val_d;
      load_q  <= load_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // ---------------------------------------------------------------- clock routing
  ccr_route_if rt ();

  assign rt.clock_source_code   = codes_q;
  assign rt.shared_clock_select = shsel_q;
  assign rt.debounce_select     = dbsel_q;
  assign rt.cout_s              = cout_s;
  assign rt.ext_s               = ext_s;
  assign rt.base_s              = base_s;
  assign rt.clk_2mhz            = c2m_q;

  ccr_router u_router (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .rt      (rt.router)
  );

  // ---------------------------------------------------------------- outputs
  assign channel_clock  = rt.channel_clock;
  assign shared_clock   = rt.shared_clock;
  assign debounce_clock = rt.debounce_clock;
  assign dout_pins      = dout_q;
  assign channel_number = chan_q;
  assign cnt_load       = load_q;
  assign cnt_mode       = mode_q;
  assign cnt_value      = val_q;
  assign prdata         = rdata_q;
  assign pslverr        = psel & penable & err_q;
  assign irq            = |(st_q & en_q);
endmodule : ccr_top

// file: ccr_properties.sv
`timescale 1ns/1ps
module ccr_properties (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [7:0]  din_pins,
  input wire logic [7:0]  dout_pins,
  input wire logic [3:0]  channel_number,
  input wire logic        cnt_load,
  input wire logic [2:0]  cnt_mode,
  input wire logic [15:0] cnt_value,
  input wire logic        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic wr_a;
  logic ch_ok;
  assign wr_a  = psel && penable && pwrite;
  assign ch_ok = pwdata[3:0] >= ccr_pkg::CH_MIN && pwdata[3:0] <= ccr_pkg::CH_MAX;

  AST_CH_RANGE: assert property (channel_number >= ccr_pkg::CH_MIN &&
    channel_number <= ccr_pkg::CH_MAX) else $error("channel number out of range");
  AST_CH_REFUSE: assert property (wr_a && paddr == ccr_pkg::OFS_CH_SEL && !ch_ok
    |-> pslverr ##1 $stable(channel_number)) else $error("bad channel taken");
  AST_CH_TAKE: assert property (wr_a && paddr == ccr_pkg::OFS_CH_SEL && ch_ok
    |=> channel_number == $past(pwdata[3:0])) else $error("channel not taken");
  AST_DOUT: assert property (wr_a && paddr == ccr_pkg::OFS_DOUT
    |=> dout_pins == $past(pwdata[7:0])) else $error("output port not written");
  AST_DOUT_HOLD: assert property ($changed(dout_pins)
    |-> $past(wr_a) && $past(paddr) == ccr_pkg::OFS_DOUT) else $error("output port moved");
  AST_LOAD: assert property (wr_a && paddr == ccr_pkg::OFS_LOAD &&
    pwdata[2:0] <= ccr_pkg::MODE_MAX |=> cnt_load && cnt_mode == $past(pwdata[2:0]) &&
    cnt_value == $past(pwdata[31:16])) else $error("load not issued");
  AST_MODE_REFUSE: assert property (wr_a && paddr == ccr_pkg::OFS_LOAD &&
    pwdata[2:0] > ccr_pkg::MODE_MAX |-> pslverr ##1 !cnt_load) else $error("bad mode loaded");
  AST_LOAD_PULSE: assert property (cnt_load
    |-> $past(wr_a) && $past(paddr) == ccr_pkg::OFS_LOAD ##1 !cnt_load)
    else $error("stray load pulse");
  AST_DIN: assert property ($stable(din_pins) [*5] ##0 (psel && penable && !pwrite &&
    paddr == ccr_pkg::OFS_DIN) |-> prdata[7:0] == din_pins) else $error("input port wrong");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr_a))
    else $error("interrupt dropped without host write");
endmodule : ccr_properties

bind ccr_top ccr_properties i_props (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pslverr, .din_pins, .dout_pins, .channel_number, .cnt_load,
  .cnt_mode, .cnt_value, .irq);

// file: ccr_chip_model.sv
`timescale 1ns/1ps
module ccr_chip_model (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [3:0]  channel_number,
  input wire logic        cnt_load,
  input wire logic [2:0]  cnt_mode,
  input wire logic [15:0] cnt_value,
  output logic     [15:0] cnt_rb_count,
  output logic     [2:0]  cnt_rb_mode,
  output logic     [7:0]  cnt_rb_status
);
  logic [2:0]  mode_q [1:12];
  logic [15:0] cnt_q  [1:12];
  // counts stand still, so a mode 5 load leaves the channel halted at its count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 1; i <= 12; i++) begin
        mode_q[i] <= '0;
        cnt_q[i]  <= '0;
      end
    end else if (cnt_load) begin
      mode_q[channel_number] <= cnt_mode;
      cnt_q[channel_number]  <= cnt_value;
    end
  end
  assign cnt_rb_count  = cnt_q[channel_number];
  assign cnt_rb_mode   = mode_q[channel_number];
  assign cnt_rb_status = {channel_number, 1'b1, mode_q[channel_number]};
endmodule : ccr_chip_model

// file: tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb_top;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, shared_clock, debounce_clock, cnt_load, irq, er, dc;
  logic [9:0]  ext_clk = '0;
  logic [11:0] chout = '0;
  logic [11:0] channel_clock;
  logic [12:0] xr;
  logic        base_clk = 1'b0;
  logic        ext_irq = 1'b0;
  logic [7:0]  din_pins = '0;
  logic [7:0]  dout_pins, rb_status, v;
  logic [3:0]  channel_number;
  logic [2:0]  cnt_mode, rb_mode, md;
  logic [15:0] cnt_value, rb_count;
  int          errors = 0;
  int          n_compared = 0;

  always #2.5 ref_clk = ~ref_clk;

  ccr_top i_dut (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .channel_external_clock_in(ext_clk), .channel_output_in(chout),
    .base_8mhz_clock(base_clk), .external_interrupt_in(ext_irq), .channel_clock,
    .shared_clock, .debounce_clock, .dout_pins, .din_pins, .channel_number, .cnt_load,
    .cnt_mode, .cnt_value, .cnt_rb_count(rb_count), .cnt_rb_mode(rb_mode),
    .cnt_rb_status(rb_status), .irq);
  ccr_chip_model i_chip (.ref_clk, .arst_n, .channel_number, .cnt_load, .cnt_mode,
    .cnt_value, .cnt_rb_count(rb_count), .cnt_rb_mode(rb_mode), .cnt_rb_status(rb_status));

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    `CHK(er, e)
    cyc(1);
  endtask : wrc

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic e);
    apb(1'b0, a, '0);
    `CHK(rd, x)
    `CHK(er, e)
  endtask : rdc

  // expected shared clock and channel clocks for one source code on all routed channels
  function automatic logic [12:0] route(input logic [1:0] k, input logic s,
                                        input logic [9:0] e, input logic [11:0] c,
                                        input logic b);
    logic        sh;
    logic [11:0] r;
    sh = s ? c[10] : b;
    for (int i = 0; i < 10; i++) begin
      case (k)
        ccr_pkg::SRC_EXT:    r[i] = e[i];
        ccr_pkg::SRC_PREV:   r[i] = (i == 0) ? c[11] : c[i-1];
        ccr_pkg::SRC_SHARED: r[i] = sh;
        default:             r[i] = c[9];
      endcase
    end
    r[10] = b;
    r[11] = c[10];
    return {sh, r};
  endfunction : route

  task automatic give_verdict;
    $display("errors %0d, compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  initial begin
    #100000;
    errors++;
    give_verdict;
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    cyc(1);
    `CHK(channel_number, 4'h1)
    rdc(ccr_pkg::OFS_CLKSEL, 32'h0, 1'b0);
    rdc(ccr_pkg::OFS_IRQ_EN, 32'h0, 1'b0);
    rdc(ccr_pkg::OFS_IRQ_ST, 32'h0, 1'b0);
    rdc(8'h20, 32'h0, 1'b1);
    for (int c = 0; c < 16; c++) begin
      wrc(ccr_pkg::OFS_CH_SEL, 32'(c), c < 1 || c > 12);
      `CHK(channel_number, (c == 0) ? 4'h1 : (c > 12) ? 4'hc : 4'(c))
    end
    for (int c = 1; c <= 12; c++) begin
      wrc(ccr_pkg::OFS_CH_SEL, 32'(c), 1'b0);
      md = 3'(c % 6);
      wrc(ccr_pkg::OFS_LOAD, {16'(c * 777), 13'h0, md}, 1'b0);
      cyc(4);
      rdc(ccr_pkg::OFS_RDBACK, {4'(c), 1'b1, md, 5'h0, md, 16'(c * 777)}, 1'b0);
    end
    wrc(ccr_pkg::OFS_LOAD, {16'h1234, 13'h0, ccr_pkg::MODE_STOP}, 1'b0);
    wrc(ccr_pkg::OFS_LOAD, {16'hffff, 13'h0, 3'h6}, 1'b1);
    cyc(4);
    rdc(ccr_pkg::OFS_RDBACK, {4'hc, 1'b1, 3'h5, 5'h0, 3'h5, 16'h1234}, 1'b0);
    for (int p = 0; p < 2; p++) begin
      v = p ? 8'ha5 : 8'h5a;
      wrc(ccr_pkg::OFS_DOUT, {24'h0, v}, 1'b0);
      `CHK(dout_pins, v)
      din_pins <= ~v;
      ext_clk  <= p ? 10'h2b5 : 10'h14a;
      chout    <= p ? 12'h2d3 : 12'hd2c;
      base_clk <= 1'(p);
      cyc(4);
      wrc(ccr_pkg::OFS_DIN, 32'h0, 1'b0);
      rdc(ccr_pkg::OFS_DIN, {24'h0, ~v}, 1'b0);
      for (int k = 0; k < 4; k++) begin
        for (int s = 0; s < 2; s++) begin
          wrc(ccr_pkg::OFS_CLKSEL, {10'h0, 1'(p), 1'(s), {10{2'(k)}}}, 1'b0);
          cyc(6);
          xr = route(2'(k), 1'(s), ext_clk, chout, base_clk);
          `CHK({shared_clock, channel_clock}, xr)
          if (p == 0) `CHK(debounce_clock, chout[10])
        end
      end
    end
    dc = debounce_clock;
    cyc(ccr_pkg::DB_HALF);
    `CHK(debounce_clock, ~dc)
    wrc(ccr_pkg::OFS_IRQ_ST, 32'h3, 1'b0);
    rdc(ccr_pkg::OFS_IRQ_ST, 32'h0, 1'b0);
    ext_irq <= 1'b1;
    cyc(5);
    rdc(ccr_pkg::OFS_IRQ_ST, 32'h2, 1'b0);
    `CHK(irq, 1'b0)
    wrc(ccr_pkg::OFS_IRQ_EN, 32'h2, 1'b0);
    cyc(2);
    `CHK(irq, 1'b1)
    ext_irq <= 1'b0;
    cyc(4);
    ext_irq <= 1'b1;
    cyc(5);
    `CHK(irq, 1'b1)
    wrc(ccr_pkg::OFS_IRQ_ST, 32'h2, 1'b0);
    cyc(2);
    `CHK(irq, 1'b0)
    rdc(ccr_pkg::OFS_IRQ_ST, 32'h0, 1'b0);
    wrc(ccr_pkg::OFS_IRQ_EN, 32'h1, 1'b0);
    chout <= 12'h800;
    cyc(5);
    `CHK(irq, 1'b1)
    rdc(ccr_pkg::OFS_IRQ_ST, 32'h1, 1'b0);
    wrc(ccr_pkg::OFS_IRQ_ST, 32'h1, 1'b0);
    cyc(2);
    `CHK(irq, 1'b0)
    give_verdict;
  end
endmodule : tb_top
